// ### src/scbu_branch_unit.sv
// Short conditional branch unit with a Wishbone register file.
// Assumes a classic Wishbone master, one clock, software supplies flags and count.
`timescale 1ns/1ps
module scbu_branch_unit (
	input wire logic i_clk, // Core clock, 200 MHz
	input wire logic i_rst, // Asynchronous reset, active high
	input wire logic i_wb_cyc, // Wishbone cycle
	input wire logic i_wb_stb, // Wishbone strobe
	input wire logic i_wb_we, // Wishbone write enable
	input wire logic [3:0] i_wb_adr, // Wishbone byte address
	input wire logic [3:0] i_wb_sel, // Wishbone byte selects
	input wire logic [31:0] i_wb_dat, // Wishbone write data
	output logic [31:0] o_wb_dat, // Wishbone read data
	output logic o_wb_ack, // Wishbone acknowledge
	output logic o_busy, // Branch in execution
	output logic o_taken // Last branch was taken
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	scbu_pkg::scbu_flags_s flags, next_flags;
	scbu_pkg::scbu_insn_s insn, next_insn;
	logic [15:0] count_register, next_count_register;
	logic [15:0] instruction_pointer, next_instruction_pointer;
	logic [31:0] rd_data, next_rd_data;
	logic ack, next_ack;
	logic start;

	// ------------------------------------------------------------
	// Execution state
	// ------------------------------------------------------------
	scbu_pkg::scbu_state_e state, next_state;
	logic [7:0] cycles_left, next_cycles_left;
	logic [7:0] cycles_used, next_cycles_used;
	logic taken, next_taken;
	logic illegal, next_illegal;
	logic busy, next_busy;

	logic cond;
	logic known;
	logic [7:0] clk_count;
	logic [15:0] displacement;
	logic [15:0] target;
	logic signed_ge;
	logic wr_hit;
	logic rd_hit;

	assign wr_hit = i_wb_cyc && i_wb_stb && i_wb_we && !ack;
	assign rd_hit = i_wb_cyc && i_wb_stb && !i_wb_we && !ack;
	// Launch only from idle so a write during execution cannot corrupt the count
	assign start = wr_hit && (i_wb_adr == scbu_pkg::ADDR_CTRL) && i_wb_sel[0]
		&& i_wb_dat[scbu_pkg::CTRL_START_BIT] && (state == scbu_pkg::SCBU_IDLE);

	// ------------------------------------------------------------
	// Decode and condition
	// ------------------------------------------------------------
	always_comb begin
		signed_ge = (flags.sign_flag == flags.overflow_flag);
		if (insn.displacement[7]) begin
			displacement = scbu_pkg::SEXT_NEG_FILL | {8'h00, insn.displacement};
		end else begin
			displacement = scbu_pkg::SEXT_POS_MASK & {8'h00, insn.displacement};
		end
		// Pointer is first advanced past the two instruction bytes
		target = instruction_pointer + scbu_pkg::INSN_LEN + displacement;
		cond = 1'b0;
		known = 1'b1;
		clk_count = scbu_pkg::CLK_FLAG_NOT_TAKEN;
		case (insn.opcode)
			scbu_pkg::OP_COUNT_ZERO: begin
				cond = (count_register == 16'h0000);
				clk_count = cond ? scbu_pkg::CLK_COUNT_ZERO_TAKEN
					: scbu_pkg::CLK_COUNT_ZERO_NOT_TAKEN;
			end
			scbu_pkg::OP_EQUAL: begin
				cond = flags.zero_flag;
				clk_count = cond ? scbu_pkg::CLK_FLAG_TAKEN : scbu_pkg::CLK_FLAG_NOT_TAKEN;
			end
			scbu_pkg::OP_SIGNED_GREATER: begin
				cond = !flags.zero_flag && signed_ge;
				clk_count = cond ? scbu_pkg::CLK_FLAG_TAKEN : scbu_pkg::CLK_FLAG_NOT_TAKEN;
			end
			scbu_pkg::OP_SIGNED_GREATER_EQUAL: begin
				cond = signed_ge;
				clk_count = cond ? scbu_pkg::CLK_FLAG_TAKEN : scbu_pkg::CLK_FLAG_NOT_TAKEN;
			end
			default: begin
				// Foreign opcodes are flagged and do nothing beyond one cycle
				known = 1'b0;
				clk_count = 8'h01;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_flags = flags;
		next_insn = insn;
		next_count_register = count_register;
		next_instruction_pointer = instruction_pointer;
		next_state = state;
		next_cycles_left = cycles_left;
		next_cycles_used = cycles_used;
		next_taken = taken;
		next_illegal = illegal;
		next_busy = busy;
		next_ack = wr_hit || rd_hit;
		next_rd_data = scbu_pkg::READ_UNMAPPED;

		// Software may load state only while idle; the branch never writes flags or count
		if (wr_hit && state == scbu_pkg::SCBU_IDLE) begin
			unique case (i_wb_adr)
				scbu_pkg::ADDR_CTRL: begin
					if (i_wb_sel[2]) begin
						next_flags.zero_flag = i_wb_dat[scbu_pkg::FLAG_ZERO_BIT];
						next_flags.sign_flag = i_wb_dat[scbu_pkg::FLAG_SIGN_BIT];
						next_flags.overflow_flag = i_wb_dat[scbu_pkg::FLAG_OVERFLOW_BIT];
					end
				end
				scbu_pkg::ADDR_INSN: begin
					if (i_wb_sel[0]) next_insn.displacement = i_wb_dat[7:0];
					if (i_wb_sel[1]) next_insn.opcode = i_wb_dat[15:8];
					if (i_wb_sel[2]) next_count_register[7:0] = i_wb_dat[23:16];
					if (i_wb_sel[3]) next_count_register[15:8] = i_wb_dat[31:24];
				end
				scbu_pkg::ADDR_POINTER: begin
					if (i_wb_sel[0]) next_instruction_pointer[7:0] = i_wb_dat[7:0];
					if (i_wb_sel[1]) next_instruction_pointer[15:8] = i_wb_dat[15:8];
				end
				default: begin
				end
			endcase
		end

		if (rd_hit) begin
			unique case (i_wb_adr)
				scbu_pkg::ADDR_CTRL:
					next_rd_data = {13'h0000, flags.overflow_flag, flags.sign_flag,
						flags.zero_flag, 16'h0000};
				scbu_pkg::ADDR_INSN:
					next_rd_data = {count_register, insn.opcode, insn.displacement};
				scbu_pkg::ADDR_STATE:
					next_rd_data = {16'h0000, cycles_used, 5'h00, illegal, taken, busy};
				scbu_pkg::ADDR_POINTER:
					next_rd_data = {16'h0000, instruction_pointer};
				default:
					next_rd_data = scbu_pkg::READ_UNMAPPED;
			endcase
		end

		unique case (state)
			scbu_pkg::SCBU_IDLE: begin
				if (start) begin
					next_state = scbu_pkg::SCBU_EXEC;
					next_busy = 1'b1;
					// Counts down from the full clock count so busy stands for exactly N cycles
					next_cycles_left = clk_count;
					next_cycles_used = 8'h01;
					next_taken = cond && known;
					next_illegal = !known;
					if (!known) begin
						next_state = scbu_pkg::SCBU_IDLE;
						next_busy = 1'b0;
					end else if (cond) begin
						next_instruction_pointer = target;
					end else begin
						next_instruction_pointer = instruction_pointer
							+ scbu_pkg::INSN_LEN;
					end
				end
			end
			scbu_pkg::SCBU_EXEC: begin
				// The pointer is already final; only the documented clock count elapses
				next_cycles_left = cycles_left - 8'h01;
				if (cycles_left == 8'h01) begin
					next_state = scbu_pkg::SCBU_IDLE;
					next_busy = 1'b0;
				end else begin
					next_cycles_used = cycles_used + 8'h01;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flags <= '0;
			insn <= '0;
			count_register <= 16'h0000;
			instruction_pointer <= scbu_pkg::RESET_POINTER;
			state <= scbu_pkg::SCBU_IDLE;
			cycles_left <= 8'h00;
			cycles_used <= 8'h00;
			taken <= 1'b0;
			illegal <= 1'b0;
			busy <= 1'b0;
			ack <= 1'b0;
			rd_data <= 32'h0000_0000;
		end else begin
			flags <= next_flags;
			insn <= next_insn;
			count_register <= next_count_register;
			instruction_pointer <= next_instruction_pointer;
			state <= next_state;
			cycles_left <= next_cycles_left;
			cycles_used <= next_cycles_used;
			taken <= next_taken;
			illegal <= next_illegal;
			busy <= next_busy;
			ack <= next_ack;
			rd_data <= next_rd_data;
		end
	end

	assign o_wb_dat = rd_data;
	assign o_wb_ack = ack;
	assign o_busy = busy;
	assign o_taken = taken;
endmodule

// ### src/scbu_pkg.sv
// Package for the short conditional branch unit: opcodes, widths, clock counts,
// register offsets and carrier structs.
// Assumes a 32-bit classic Wishbone master drives the register file.
package scbu_pkg;
	localparam logic [7:0] OP_COUNT_ZERO = 8'hE3;
	localparam logic [7:0] OP_EQUAL = 8'h74;
	localparam logic [7:0] OP_SIGNED_GREATER = 8'h7F;
	localparam logic [7:0] OP_SIGNED_GREATER_EQUAL = 8'h7D;

	localparam logic [7:0] CLK_COUNT_ZERO_TAKEN = 8'h0F;
	localparam logic [7:0] CLK_COUNT_ZERO_NOT_TAKEN = 8'h05;
	localparam logic [7:0] CLK_FLAG_TAKEN = 8'h0D;
	localparam logic [7:0] CLK_FLAG_NOT_TAKEN = 8'h04;

	localparam logic [15:0] SEXT_NEG_FILL = 16'hFF00;
	localparam logic [15:0] SEXT_POS_MASK = 16'h00FF;
	localparam logic [15:0] INSN_LEN = 16'h0002;

	// Byte addresses of the word registers
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_INSN = 4'h4;
	localparam logic [3:0] ADDR_STATE = 4'h8;
	localparam logic [3:0] ADDR_POINTER = 4'hC;

	// Control and state register fields
	localparam int CTRL_START_BIT = 0;
	localparam int STATE_BUSY_BIT = 0;
	localparam int STATE_TAKEN_BIT = 1;
	localparam int STATE_ILLEGAL_BIT = 2;
	localparam int STATE_CYCLES_LSB = 8;
	localparam int FLAG_ZERO_BIT = 16;
	localparam int FLAG_SIGN_BIT = 17;
	localparam int FLAG_OVERFLOW_BIT = 18;
	localparam int CTRL_COUNT_LSB = 16;

	localparam logic [15:0] RESET_POINTER = 16'h0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	typedef struct packed {
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
	} scbu_flags_s;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] displacement;
	} scbu_insn_s;

	typedef enum logic [1:0] {
		SCBU_IDLE,
		SCBU_EXEC
	} scbu_state_e;
endpackage

// ### verification/scbu_branch_unit_bench.sv
// Self-checking bench for the short conditional branch unit.
// Assumes the checker binds itself; the bench is the bus master.
`timescale 1ns/1ps
module scbu_branch_unit_bench;
	typedef struct packed {
		logic [7:0] op;
		logic [2:0] fl; // Overflow, sign, zero
		logic [15:0] cnt;
		logic [7:0] disp;
		logic [15:0] ip;
		logic tk;
	} scbu_row_s;
	logic i_clk = 1'h0, i_rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, q, o_wb_dat;
	logic o_wb_ack, o_busy, o_taken;
	int miscompares = 0, total_checks = 0, cycles = 0;
	scbu_row_s rows [10] = '{'{8'hE3, 3'h0, 16'h0000, 8'h80, 16'h0010, 1'h1},
		'{8'hE3, 3'h7, 16'h0100, 8'h05, 16'h0010, 1'h0},
		'{8'h74, 3'h1, 16'h0000, 8'h7F, 16'hFFF0, 1'h1},
		'{8'h74, 3'h0, 16'h0000, 8'h10, 16'h0020, 1'h0},
		'{8'h7F, 3'h6, 16'h0000, 8'hFE, 16'h0030, 1'h1},
		'{8'h7F, 3'h1, 16'h0000, 8'h04, 16'h0030, 1'h0},
		'{8'h7F, 3'h4, 16'h0000, 8'h04, 16'h0030, 1'h0},
		'{8'h7D, 3'h1, 16'h0000, 8'hF0, 16'h0040, 1'h1},
		'{8'h7D, 3'h2, 16'h0000, 8'h04, 16'h0040, 1'h0},
		'{8'h7D, 3'h4, 16'h0000, 8'h04, 16'h0040, 1'h0}};
	scbu_branch_unit i_scbu_branch_unit (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_busy(o_busy), .o_taken(o_taken));
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
	end
	function automatic logic [15:0] ptr(input scbu_row_s r);
		return r.ip + 16'h0002 + (r.tk ? {{8{r.disp[7]}}, r.disp} : 16'h0000);
	endfunction
	function automatic logic [7:0] clks(input scbu_row_s r);
		return r.op == 8'hE3 ? (r.tk ? 8'h0F : 8'h05) : (r.tk ? 8'h0D : 8'h04);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask
	// Ack is read right after each rising edge, which gives the value sampled at that edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= (a == 4'h0) ? 4'h5 : 4'hF;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'h1 && n < 50);
		q = o_wb_dat;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n >= 50) miscompares++;
	endtask
	task automatic go(input scbu_row_s r);
		wb(1'h1, 4'h4, {r.cnt, r.op, r.disp});
		wb(1'h1, 4'hC, {16'h0000, r.ip});
		// Flags first: a start in the same write would test the old flags
		wb(1'h1, 4'h0, {13'h0, r.fl, 16'h0000});
		wb(1'h1, 4'h0, {13'h0, r.fl, 16'h0001});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (o_busy !== 1'h0 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 40) miscompares++;
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'h0;
		foreach (rows[i]) begin
			go(rows[i]);
			wait_idle();
			chk({31'h0, o_taken}, {31'h0, rows[i].tk});
			wb(1'h0, 4'h8, 32'h0);
			chk(q, {16'h0, clks(rows[i]), 6'h0, rows[i].tk, 1'h0});
			wb(1'h0, 4'hC, 32'h0);
			chk(q, {16'h0, ptr(rows[i])});
			wb(1'h0, 4'h0, 32'h0);
			chk(q, {13'h0, rows[i].fl, 16'h0});
			wb(1'h0, 4'h4, 32'h0);
			chk(q, {rows[i].cnt, rows[i].op, rows[i].disp});
			$display("row %0d done", i);
		end
		// Pointer write during a branch must be dropped
		go(rows[0]);
		wb(1'h1, 4'hC, 32'h1234);
		chk({31'h0, o_busy}, 32'h1);
		wait_idle();
		wb(1'h0, 4'hC, 32'h0);
		chk(q, {16'h0, ptr(rows[0])});
		$display("busy write test done");
		go('{8'h75, 3'h1, 16'h0000, 8'h10, 16'h0050, 1'h0});
		chk({30'h0, o_busy, o_taken}, 32'h0);
		wb(1'h0, 4'h8, 32'h0);
		chk({29'h0, q[2:0]}, 32'h4);
		wb(1'h0, 4'hC, 32'h0);
		chk(q, 32'h0050);
		wb(1'h0, 4'h2, 32'h0);
		chk(q, 32'h0);
		$display("foreign and unmapped test done");
		go(rows[0]);
		i_rst <= 1'h1;
		repeat (3) @(posedge i_clk);
		chk({30'h0, o_busy, o_taken}, 32'h0);
		i_rst <= 1'h0;
		wb(1'h0, 4'hC, 32'h0);
		chk(q, 32'h0);
		$display("reset test done");
		final_report();
	end
endmodule

// ### verification/scbu_branch_unit_sva.sv
// Port checker for the short conditional branch unit.
// Assumes one clock domain and the unit's register map.
`timescale 1ns/1ps
module scbu_branch_unit_sva (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_busy,
	input wire logic o_taken
);
	logic [7:0] opc, next_opc;
	logic [4:0] cnt, next_cnt;
	logic req, go, ok;
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign go = req && i_wb_we && !o_busy && i_wb_adr == 4'h0 && i_wb_sel[0] && i_wb_dat[0];
	assign ok = opc inside {8'hE3, 8'h74, 8'h7F, 8'h7D};
	// Opcode shadow follows only writes the unit accepts
	always_comb begin
		next_opc = (req && i_wb_we && !o_busy && i_wb_adr == 4'h4 && i_wb_sel[1]) ?
			i_wb_dat[15:8] : opc;
		next_cnt = o_busy ? cnt + 5'h01 : 5'h00;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			opc <= 8'h00;
			cnt <= 5'h00;
		end else begin
			opc <= next_opc;
			cnt <= next_cnt;
		end
	end
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_ack_next; req |=> o_wb_ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_go; go && ok |=> o_busy; endproperty
	a_go: assert property (p_go) else $error("start did not raise busy");
	property p_min; $rose(o_busy) |-> o_busy[*4]; endproperty
	a_min: assert property (p_min) else $error("busy too short");
	property p_len; $fell(o_busy) |-> cnt == (opc == 8'hE3 ?
		(o_taken ? 5'h0F : 5'h05) : (o_taken ? 5'h0D : 5'h04)); endproperty
	a_len: assert property (p_len) else $error("wrong clock count");
	property p_bad; go && !ok |=> !o_busy && !o_taken; endproperty
	a_bad: assert property (p_bad) else $error("foreign opcode acted");
	property p_hold; o_busy && $past(o_busy) |-> $stable(o_taken); endproperty
	a_hold: assert property (p_hold) else $error("taken moved mid branch");
	property p_idle; !o_busy && !go |=> $stable(o_taken); endproperty
	a_idle: assert property (p_idle) else $error("taken moved while idle");
endmodule
bind scbu_branch_unit scbu_branch_unit_sva i_sva (.i_clk(i_clk), .i_rst(i_rst),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_busy(o_busy), .o_taken(o_taken));
